//--- hw/iprc_top.sv
// interrupt priority, control and reset logic top level
`default_nettype none
module iprc_top
  import iprc_pkg::*;
#(
  parameter int OSC_DELAY_CYC = IPRC_OSC_DELAY_CYC,
  parameter int WDOG_BASE_CYC = IPRC_WDOG_BASE_CYC,
  parameter int NUM_SRC = IPRC_NUM_SRC
) (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire iprc_bus_req_t i_bus,
  output logic [7:0] o_rdata,
  input wire logic [NUM_SRC-1:0] i_src_req,
  input wire logic i_ext_int_n,
  input wire logic i_nonmaskable_int_n,
  input wire logic i_cpu_i_mask,
  input wire logic i_cpu_x_mask,
  input wire logic i_int_ack,
  input wire logic i_stop_exit,
  input wire logic i_clk_slow,
  input wire logic i_mode_select_a,
  input wire logic i_mode_select_b,
  input wire logic i_background_debug_pin,
  input wire logic i_reset_pin,
  input wire logic i_periodic_event,
  output logic o_reset_pin_oe_n,
  output logic o_core_reset,
  output iprc_rst_vec_t o_reset_vector,
  output logic o_irq,
  output logic [7:0] o_irq_vector,
  output logic o_nmi,
  output logic o_cpu_mask_set,
  output logic o_stop_hold,
  output logic [2:0] o_mode
);
  logic [7:0] ctrl_q;
  logic edge_wr_seen_q;
  logic dly_wr_seen_q;
  logic [7:0] prio_q;
  logic [23:0] force_q;
  logic ext_prev_q;
  logic ext_latch_q;
  logic [2:0] mode_q;
  logic mode_cap_q;
  logic [2:0] wdog_rate_q;
  logic wdog_window_q;
  logic clkmon_en_q;
  logic wdog_armed_q;
  logic [19:0] wdog_cnt_q;
  logic wdog_fail_q;
  logic [12:0] stop_cnt_q;
  logic periodic_flag_q;
  logic [1:0] periodic_rate_q;
  logic core_reset;
  logic special;
  logic wr;
  logic [NUM_SRC-1:0] pend;
  logic [19:0] wdog_period;
  logic wdog_bad;
  logic [7:0] rdata_d;
  logic [7:0] vec_d;
  logic found;
  logic [23:0] test_view;

  assign wr = i_bus.wr;
  // mode bit 2 is the special-mode-n level: low means special
  assign special = !mode_q[2];

  // ********************************************************
  // reset sequencer
  // ********************************************************
  iprc_reset_seq #(
    .OSC_DELAY_CYC(OSC_DELAY_CYC)
  ) u_seq (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_wdog_fail(wdog_fail_q),
    .i_clkmon_fail(clkmon_en_q && i_clk_slow),
    .i_reset_pin(i_reset_pin),
    .o_reset_pin_oe_n(o_reset_pin_oe_n),
    .o_core_reset(core_reset),
    .o_vector(o_reset_vector)
  );
  assign o_core_reset = core_reset;

  // ********************************************************
  // mode capture
  // ********************************************************
  // latch select pins as reset releases
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      mode_q <= 3'h0;
      mode_cap_q <= 1'b0;
    end else if (!mode_cap_q) begin
      mode_q <= {i_background_debug_pin, i_mode_select_b, i_mode_select_a};
      mode_cap_q <= 1'b1;
    end
  end
  assign o_mode = mode_q;

  // ********************************************************
  // control register
  // ********************************************************
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      ctrl_q <= IPRC_IRQ_CONTROL_RST;
      edge_wr_seen_q <= 1'b0;
      dly_wr_seen_q <= 1'b0;
    end else if (wr && i_bus.addr == IPRC_OFF_IRQ_CONTROL && mode_cap_q) begin
      edge_wr_seen_q <= 1'b1;
      dly_wr_seen_q <= 1'b1;
      // once in normal, skip first in special
      if (special ? edge_wr_seen_q : !edge_wr_seen_q) begin
        ctrl_q[IPRC_BIT_EDGE_SEL] <= i_bus.wdata[IPRC_BIT_EDGE_SEL];
      end
      ctrl_q[IPRC_BIT_CONNECT] <= i_bus.wdata[IPRC_BIT_CONNECT];
      if (special || !dly_wr_seen_q) begin
        ctrl_q[IPRC_BIT_STOP_DLY] <= i_bus.wdata[IPRC_BIT_STOP_DLY];
      end
    end
  end

  // ********************************************************
  // priority elevation and test forcing
  // ********************************************************
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      prio_q <= IPRC_PRIO_ELEV_RST;
      force_q <= 24'h0;
    end else begin
      if (wr && i_bus.addr == IPRC_OFF_PRIO_ELEV && i_cpu_i_mask) begin
        prio_q <= i_bus.wdata;
      end
      // test writes only in special modes
      if (wr && special) begin
        if (i_bus.addr == IPRC_OFF_TEST_LO) force_q[7:0] <= i_bus.wdata;
        if (i_bus.addr == IPRC_OFF_TEST_HI) force_q[15:8] <= i_bus.wdata;
        if (i_bus.addr == IPRC_OFF_TEST_TOP) force_q[23:16] <= i_bus.wdata;
      end
    end
  end

  // ********************************************************
  // external interrupt pin
  // ********************************************************
  // edge latch clears when the cpu takes the external vector
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      ext_prev_q <= 1'b1;
      ext_latch_q <= 1'b0;
    end else begin
      ext_prev_q <= i_ext_int_n;
      // falling edge latched, set beats clear
      if (ctrl_q[IPRC_BIT_CONNECT] && ext_prev_q && !i_ext_int_n) begin
        ext_latch_q <= 1'b1;
      end else if (i_int_ack && o_irq_vector == IPRC_VEC_EXT_INT) begin
        ext_latch_q <= 1'b0;
      end
    end
  end

  // pending vector: index k holds vector f2 - 2k
  always_comb begin
    pend = i_src_req;
    pend[0] = ctrl_q[IPRC_BIT_CONNECT] &&
      (ctrl_q[IPRC_BIT_EDGE_SEL] ? ext_latch_q : !i_ext_int_n);
    // test bit j forces vector f2 - 2(22 - j)
    // three test registers only reach vectors c6..f2
    if (special) begin
      for (int k = 0; k < 23; k++) begin
        pend[k] = pend[k] | force_q[22 - k];
      end
    end
  end

  // request view in the same bit order as forcing
  for (genvar j = 0; j < 23; j++) begin : g_test_view
    assign test_view[j] = pend[22 - j];
  end
  // top bit is the nonmaskable vector: shown, not forced
  assign test_view[23] = force_q[23] | !i_nonmaskable_int_n;

  // ********************************************************
  // priority resolution
  // ********************************************************
  logic [7:0] elev;
  // unimplemented or high value means pin
  assign elev = (prio_q > IPRC_VEC_EXT_INT || prio_q < IPRC_VEC_LOWEST ||
    prio_q[0]) ? IPRC_VEC_EXT_INT : prio_q;

  always_comb begin
    vec_d = IPRC_VEC_EXT_INT;
    found = 1'b0;
    for (int k = NUM_SRC - 1; k >= 0; k--) begin
      if (pend[k]) begin
        vec_d = 8'(IPRC_VEC_EXT_INT - 8'(2 * k));
        found = 1'b1;
      end
    end
    for (int k = 0; k < NUM_SRC; k++) begin
      if (pend[k] && 8'(IPRC_VEC_EXT_INT - 8'(2 * k)) == elev) begin
        vec_d = elev;
      end
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      o_irq_vector <= IPRC_VEC_EXT_INT;
      o_irq <= 1'b0;
      o_nmi <= 1'b0;
    end else begin
      o_irq_vector <= vec_d;
      o_irq <= found && !i_cpu_i_mask && !core_reset;
      o_nmi <= !i_nonmaskable_int_n && !i_cpu_x_mask && !core_reset;
    end
  end
  // masks and stop inhibit set in reset
  assign o_cpu_mask_set = core_reset;

  // ********************************************************
  // watchdog and clock control
  // ********************************************************
  assign wdog_period = 20'(WDOG_BASE_CYC) << wdog_rate_q;
  assign wdog_bad = wr && i_bus.addr == IPRC_OFF_WDOG_SERVICE &&
    wdog_rate_q != 3'h0 &&
    ((i_bus.wdata != IPRC_WDOG_KEY1 && i_bus.wdata != IPRC_WDOG_KEY2) ||
    (i_bus.wdata == IPRC_WDOG_KEY2 && !wdog_armed_q) ||
    // early write in window mode resets
    (wdog_window_q && wdog_cnt_q < wdog_period - (wdog_period >> 2)));

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      wdog_rate_q <= IPRC_WDOG_RATE_RST;
      wdog_window_q <= 1'b0;
      clkmon_en_q <= 1'b0;
      wdog_armed_q <= 1'b0;
      wdog_cnt_q <= 20'h0;
      wdog_fail_q <= 1'b0;
    end else if (core_reset) begin
      // internal resets restore the setup as well
      wdog_rate_q <= IPRC_WDOG_RATE_RST;
      wdog_window_q <= 1'b0;
      clkmon_en_q <= 1'b0;
      wdog_cnt_q <= 20'h0;
      wdog_armed_q <= 1'b0;
      wdog_fail_q <= 1'b0;
    end else begin
      if (wr && i_bus.addr == IPRC_OFF_WDOG_CTRL) begin
        wdog_rate_q <= i_bus.wdata[2:0];
        wdog_window_q <= i_bus.wdata[IPRC_BIT_WDOG_WINDOW];
        clkmon_en_q <= i_bus.wdata[IPRC_BIT_CLKMON_EN];
      end
      wdog_cnt_q <= wdog_cnt_q + 20'h1;
      // 55 arms, AA services, else reset
      if (wdog_bad || (wdog_rate_q != 3'h0 && wdog_cnt_q >= wdog_period)) begin
        wdog_fail_q <= 1'b1;
      end else if (wr && i_bus.addr == IPRC_OFF_WDOG_SERVICE) begin
        wdog_armed_q <= i_bus.wdata == IPRC_WDOG_KEY1;
        if (i_bus.wdata == IPRC_WDOG_KEY2) wdog_cnt_q <= 20'h0;
      end
    end
  end

  // periodic flag and rate, cleared by reset, flag write-one-clear
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      periodic_flag_q <= 1'b0;
      periodic_rate_q <= 2'h0;
    end else if (core_reset) begin
      periodic_flag_q <= 1'b0;
      periodic_rate_q <= 2'h0;
    end else begin
      if (wr && i_bus.addr == IPRC_OFF_PERIODIC) begin
        periodic_rate_q <= i_bus.wdata[1:0];
      end
      if (i_periodic_event && periodic_rate_q != 2'h0) begin
        periodic_flag_q <= 1'b1;
      end else if (wr && i_bus.addr == IPRC_OFF_PERIODIC && i_bus.wdata[7]) begin
        periodic_flag_q <= 1'b0;
      end
    end
  end

  // stop exit waits 4096 cycles if enabled
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      stop_cnt_q <= 13'h0;
    end else if (i_stop_exit && ctrl_q[IPRC_BIT_STOP_DLY]) begin
      stop_cnt_q <= 13'(OSC_DELAY_CYC);
    end else if (stop_cnt_q != 13'h0) begin
      stop_cnt_q <= stop_cnt_q - 13'h1;
    end
  end
  assign o_stop_hold = stop_cnt_q != 13'h0;

  // ********************************************************
  // read port
  // ********************************************************
  always_comb begin
    rdata_d = 8'h0;
    unique case (i_bus.addr)
      IPRC_OFF_IRQ_CONTROL: rdata_d = ctrl_q;
      IPRC_OFF_PRIO_ELEV: rdata_d = prio_q;
      // test regs read zero in normal modes
      IPRC_OFF_TEST_LO: rdata_d = special ? test_view[7:0] : 8'h0;
      IPRC_OFF_TEST_HI: rdata_d = special ? test_view[15:8] : 8'h0;
      IPRC_OFF_TEST_TOP: rdata_d = special ? test_view[23:16] : 8'h0;
      IPRC_OFF_WDOG_CTRL: rdata_d = {wdog_window_q, clkmon_en_q, 3'h0, wdog_rate_q};
      IPRC_OFF_RESET_STATUS: rdata_d = {4'h0, 4'(o_reset_vector)};
      IPRC_OFF_MODE: rdata_d = {5'h0, mode_q};
      IPRC_OFF_PERIODIC: rdata_d = {periodic_flag_q, 5'h0, periodic_rate_q};
      default: rdata_d = 8'h0;
    endcase
  end

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      o_rdata <= 8'h0;
    end else begin
      o_rdata <= i_bus.rd ? rdata_d : 8'h0;
    end
  end
endmodule : iprc_top
`default_nettype wire

//--- include/iprc_pkg.sv
// package: register map, field layout, reset values and timing counts
`default_nettype none
package iprc_pkg;
  // ********************************************************
  // register map
  // ********************************************************
  localparam logic [7:0] IPRC_OFF_IRQ_CONTROL = 8'h1e;
  localparam logic [7:0] IPRC_OFF_PRIO_ELEV = 8'h1f;
  localparam logic [7:0] IPRC_OFF_TEST_LO = 8'h20;
  localparam logic [7:0] IPRC_OFF_TEST_HI = 8'h21;
  localparam logic [7:0] IPRC_OFF_TEST_TOP = 8'h22;
  localparam logic [7:0] IPRC_OFF_WDOG_CTRL = 8'h23;
  localparam logic [7:0] IPRC_OFF_WDOG_SERVICE = 8'h24;
  localparam logic [7:0] IPRC_OFF_RESET_STATUS = 8'h25;
  localparam logic [7:0] IPRC_OFF_MODE = 8'h26;
  localparam logic [7:0] IPRC_OFF_PERIODIC = 8'h27;
  // ********************************************************
  // fields and reset values
  // ********************************************************
  localparam int IPRC_BIT_EDGE_SEL = 7;
  localparam int IPRC_BIT_CONNECT = 6;
  localparam int IPRC_BIT_STOP_DLY = 5;
  localparam int IPRC_BIT_WDOG_WINDOW = 7;
  localparam int IPRC_BIT_CLKMON_EN = 6;
  localparam logic [7:0] IPRC_IRQ_CONTROL_RST = 8'h60;
  localparam logic [7:0] IPRC_PRIO_ELEV_RST = 8'hf2;
  localparam logic [2:0] IPRC_WDOG_RATE_RST = 3'h7;
  localparam logic [7:0] IPRC_WDOG_KEY1 = 8'h55;
  localparam logic [7:0] IPRC_WDOG_KEY2 = 8'haa;
  localparam logic [7:0] IPRC_VEC_EXT_INT = 8'hf2;
  localparam logic [7:0] IPRC_VEC_LOWEST = 8'hb0;
  localparam logic [7:0] IPRC_VEC_FORCE_BASE = 8'hb6;
  localparam int IPRC_NUM_SRC = 34;
  // ********************************************************
  // timing
  // ********************************************************
  localparam int IPRC_CLK_MHZ = 50;
  localparam int IPRC_OSC_DELAY_CYC = 4096;
  localparam int IPRC_RECOVER_CYC = 17;
  localparam int IPRC_SAMPLE_CYC = 9;
  localparam int IPRC_WDOG_BASE_CYC = 1024;
  // ********************************************************
  // types
  // ********************************************************
  typedef enum logic [3:0] {
    IPRC_VEC_PIN = 4'h0,
    IPRC_VEC_WDOG = 4'h1,
    IPRC_VEC_CLKMON = 4'h2
  } iprc_rst_vec_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } iprc_bus_req_t;
endpackage : iprc_pkg
`default_nettype wire

//--- hw/iprc_reset_seq.sv
// reset sequencer: pin drive, source classification, oscillator delay
`default_nettype none
module iprc_reset_seq
  import iprc_pkg::*;
#(
  parameter int OSC_DELAY_CYC = IPRC_OSC_DELAY_CYC
) (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_wdog_fail,
  input wire logic i_clkmon_fail,
  input wire logic i_reset_pin,
  output logic o_reset_pin_oe_n,
  output logic o_core_reset,
  output iprc_rst_vec_t o_vector
);
  typedef enum logic [4:0] {
    S_RUN = 5'b00001,
    S_OSC = 5'b00010,
    S_DRIVE = 5'b00100,
    S_SAMPLE = 5'b01000,
    S_PIN = 5'b10000
  } iprc_seq_t;
  iprc_seq_t state_q;
  logic [12:0] cnt_q;
  logic clkmon_q;
  // set only by watchdog or monitor causes; power-on enters with it clear
  logic internal_q;

  // ********************************************************
  // sequence
  // ********************************************************
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      state_q <= S_DRIVE;
      cnt_q <= 13'h0;
      clkmon_q <= 1'b0;
      internal_q <= 1'b0;
      o_vector <= IPRC_VEC_PIN;
    end else begin
      unique case (state_q)
        S_RUN: begin
          cnt_q <= 13'h0;
          if (i_clkmon_fail) begin
            clkmon_q <= 1'b1;
            internal_q <= 1'b1;
            state_q <= S_OSC;
          end else if (i_wdog_fail) begin
            clkmon_q <= 1'b0;
            internal_q <= 1'b1;
            state_q <= S_DRIVE;
          end else if (!i_reset_pin) begin
            o_vector <= IPRC_VEC_PIN;
            state_q <= S_PIN;
          end
        end
        S_OSC: begin
          cnt_q <= cnt_q + 13'h1;
          if (cnt_q == 13'(OSC_DELAY_CYC - 1)) begin
            cnt_q <= 13'h0;
            state_q <= S_DRIVE;
          end
        end
        S_DRIVE: begin
          cnt_q <= cnt_q + 13'h1;
          if (cnt_q == 13'(IPRC_RECOVER_CYC - 1)) begin
            cnt_q <= 13'h0;
            state_q <= S_SAMPLE;
          end
        end
        S_SAMPLE: begin
          cnt_q <= cnt_q + 13'h1;
          if (cnt_q == 13'(IPRC_SAMPLE_CYC - 1)) begin
            cnt_q <= 13'h0;
            internal_q <= 1'b0;
            if (!i_reset_pin) begin
              o_vector <= IPRC_VEC_PIN;
              state_q <= S_PIN;
            end else begin
              // own vector per internal source, power-on as pin
              o_vector <= !internal_q ? IPRC_VEC_PIN :
                clkmon_q ? IPRC_VEC_CLKMON : IPRC_VEC_WDOG;
              state_q <= S_RUN;
            end
          end
        end
        // external reset: wait for release
        S_PIN: begin
          cnt_q <= 13'h0;
          clkmon_q <= 1'b0;
          if (i_reset_pin) state_q <= S_RUN;
        end
      endcase
    end
  end

  assign o_reset_pin_oe_n = !(state_q == S_OSC || state_q == S_DRIVE);
  assign o_core_reset = (state_q != S_RUN);
endmodule : iprc_reset_seq
`default_nettype wire

//--- tb/iprc_top_properties.sv
// checker: port-level properties of the interrupt and reset block
`default_nettype none
module iprc_top_checker
  import iprc_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire iprc_bus_req_t i_bus,
  input wire logic [7:0] o_rdata,
  input wire logic i_reset_pin,
  input wire logic o_reset_pin_oe_n,
  input wire logic o_core_reset,
  input wire iprc_rst_vec_t o_reset_vector,
  input wire logic o_irq,
  input wire logic o_cpu_mask_set,
  input wire logic [2:0] o_mode
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_reset);
  // ********
  // helpers
  // ********
  logic [15:0] lo_q;
  // saturates: the clock-fail hold is long
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      lo_q <= 16'h0000;
    end else if (o_reset_pin_oe_n) begin
      lo_q <= 16'h0000;
    end else if (lo_q != 16'hffff) begin
      lo_q <= lo_q + 16'h0001;
    end
  end
  // ********
  // properties
  // ********
  a_mask_follow: assert property (
    o_cpu_mask_set == o_core_reset) else $error("mask not tied to reset");
  a_async_entry: assert property (
    disable iff (1'b0) i_reset |-> o_core_reset && !o_reset_pin_oe_n)
    else $error("reset entry not immediate");
  a_drive_len: assert property (
    $rose(o_reset_pin_oe_n) |-> lo_q >= 16'h0010)
    else $error("reset pin drive too short");
  a_sample_gap: assert property (
    $rose(o_reset_pin_oe_n) |-> o_core_reset [*8])
    else $error("left reset before sampling pin");
  a_exit_pin: assert property (
    $fell(o_core_reset) |-> i_reset_pin) else $error("exit with pin low");
  a_test_zero: assert property (
    $past(i_bus.rd) && $past(i_bus.addr) == IPRC_OFF_TEST_LO && o_mode[2]
    |-> o_rdata == 8'h00) else $error("test reg nonzero in normal mode");
  a_mode_hold: assert property (
    !$past(i_reset) && !(i_bus.wr && i_bus.addr == IPRC_OFF_MODE)
    |=> $stable(o_mode)) else $error("mode bits changed");
  a_bad_key: assert property (
    i_bus.wr && i_bus.addr == IPRC_OFF_WDOG_SERVICE && !o_core_reset &&
    i_bus.wdata != IPRC_WDOG_KEY1 && i_bus.wdata != IPRC_WDOG_KEY2
    |-> ##[1:4] o_core_reset) else $error("bad key gave no reset");
  c_wdog: cover property ($fell(o_core_reset) && o_reset_vector == IPRC_VEC_WDOG);
  c_clkmon: cover property (
    $fell(o_core_reset) && o_reset_vector == IPRC_VEC_CLKMON);
  c_irq: cover property ($rose(o_irq));
endmodule : iprc_top_checker
`default_nettype wire

//--- tb/iprc_far_side.sv
// far-side model: reset pin with pull-up and an external reset source
`default_nettype none
module iprc_far_side #(
  parameter int HOLD_CYC = 40
) (
  input wire logic i_clk_sys,
  input wire logic i_hold_req,
  input wire logic i_pin_oe_n,
  output logic o_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  int hold_cnt = 0;
  // external source holds long
  // above the 26 drive and sample cycles so it is not taken as watchdog
  always @(posedge i_clk_sys) begin
    if (i_hold_req) hold_cnt <= HOLD_CYC;
    else if (hold_cnt > 0) hold_cnt <= hold_cnt - 1;
  end
  // pull-up wins when nobody pulls low
  assign o_pin = i_pin_oe_n && hold_cnt == 0;
endmodule : iprc_far_side
`default_nettype wire

//--- tb/iprc_top_test.sv
// testbench for the interrupt priority and reset block
`default_nettype none
module iprc_top_test;
  import iprc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int OSC = 16;
  logic i_clk_sys, i_reset, i_ext_int_n, i_cpu_i_mask, i_cpu_x_mask;
  logic i_int_ack, i_stop_exit, i_clk_slow, hold, pin;
  logic nmi_n, background_debug_pin, pev, o_nmi;
  iprc_bus_req_t i_bus;
  logic [33:0] src;
  logic [7:0] o_rdata, o_irq_vector;
  logic o_reset_pin_oe_n, o_core_reset, o_irq, o_cpu_mask_set, o_stop_hold;
  iprc_rst_vec_t o_reset_vector;
  logic [2:0] o_mode;
  int fails, checks_done, cyc, lo, c;
  iprc_top #(.OSC_DELAY_CYC(OSC), .WDOG_BASE_CYC(16)) iprc_top_i (
    .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_bus(i_bus),
    .o_rdata(o_rdata), .i_src_req(src), .i_ext_int_n(i_ext_int_n),
    .i_nonmaskable_int_n(nmi_n), .i_cpu_i_mask(i_cpu_i_mask),
    .i_cpu_x_mask(i_cpu_x_mask), .i_int_ack(i_int_ack),
    .i_stop_exit(i_stop_exit), .i_clk_slow(i_clk_slow),
    .i_mode_select_a(1'b1), .i_mode_select_b(1'b0),
    .i_background_debug_pin(background_debug_pin), .i_reset_pin(pin),
    .i_periodic_event(pev), .o_reset_pin_oe_n(o_reset_pin_oe_n),
    .o_core_reset(o_core_reset), .o_reset_vector(o_reset_vector),
    .o_irq(o_irq), .o_irq_vector(o_irq_vector), .o_nmi(o_nmi),
    .o_cpu_mask_set(o_cpu_mask_set), .o_stop_hold(o_stop_hold),
    .o_mode(o_mode));
  iprc_far_side iprc_far_side_i (.i_clk_sys(i_clk_sys), .i_hold_req(hold),
    .i_pin_oe_n(o_reset_pin_oe_n), .o_pin(pin));
  initial begin
    i_clk_sys = 1'b0;
    forever #10 i_clk_sys = ~i_clk_sys;
  end
  // ********
  // tasks
  // ********
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_bus <= '{a, d, 1'b1, 1'b0};
    @(posedge i_clk_sys);
    i_bus <= '0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clk_sys);
    i_bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge i_clk_sys);
    i_bus <= '0;
    #1 chk(o_rdata, e);
  endtask : rd
  // no-request checks always wait the full span
  task automatic wirq(input logic v, input logic [7:0] e);
    for (int n = 0; n < 10; n++) begin
      @(posedge i_clk_sys);
      #1;
      if (v && o_irq === 1'b1 && o_irq_vector === e) break;
    end
    chk({7'h00, o_irq}, {7'h00, v});
    if (v) chk(o_irq_vector, e);
  endtask : wirq
  task automatic stop_cnt(output int n);
    @(posedge i_clk_sys);
    i_stop_exit <= 1'b1;
    @(posedge i_clk_sys);
    i_stop_exit <= 1'b0;
    n = 0;
    repeat (OSC + 10) begin
      @(posedge i_clk_sys);
      #1 if (o_stop_hold === 1'b1) n++;
    end
  endtask : stop_cnt
  task automatic rwait(output int n);
    bit seen;
    n = 0;
    seen = 0;
    for (int k = 0; k < 400; k++) begin
      @(posedge i_clk_sys);
      #1 if (o_reset_pin_oe_n === 1'b0) n++;
      if (o_core_reset === 1'b1) seen = 1;
      if (seen && o_core_reset === 1'b0) break;
    end
    chk({7'h00, o_core_reset}, 8'h00);
  endtask : rwait
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results
  // cycle ceiling: the whole run needs under a thousand cycles
  always @(posedge i_clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      results();
    end
  end
  // ********
  // tests
  // ********
  initial begin
    {i_ext_int_n, i_cpu_i_mask, i_cpu_x_mask} = 3'b111;
    {i_int_ack, i_stop_exit, i_clk_slow, hold} = 4'h0;
    {nmi_n, background_debug_pin, pev} = 3'b110;
    i_bus = '0;
    src = '0;
    {fails, checks_done, cyc} = 0;
    i_reset = 1'b1;
    repeat (3) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    i_cpu_i_mask <= 1'b0;
    i_cpu_x_mask <= 1'b0;
    rwait(lo);
    chk({4'h0, o_reset_vector}, {4'h0, IPRC_VEC_PIN});
    rd(IPRC_OFF_IRQ_CONTROL, 8'h60);
    rd(IPRC_OFF_PRIO_ELEV, 8'hf2);
    chk({5'h00, o_mode}, 8'h05);
    rd(8'h40, 8'h00);
    nmi_n <= 1'b0;
    @(posedge i_clk_sys);
    #1 chk({7'h00, o_nmi}, 8'h01);
    i_cpu_x_mask <= 1'b1;
    @(posedge i_clk_sys);
    #1 chk({7'h00, o_nmi}, 8'h00);
    {nmi_n, i_cpu_x_mask} <= 2'b10;
    $display("defaults done");
    i_ext_int_n <= 1'b0;
    wirq(1'b1, 8'hf2);
    i_ext_int_n <= 1'b1;
    wirq(1'b0, 8'h00);
    stop_cnt(c);
    chk({7'h00, c >= OSC - 2 && c <= OSC + 2}, 8'h01);
    $display("level and stop delay done");
    wr(IPRC_OFF_IRQ_CONTROL, 8'hc0);
    rd(IPRC_OFF_IRQ_CONTROL, 8'hc0);
    stop_cnt(c);
    chk(c[7:0], 8'h00);
    wr(IPRC_OFF_IRQ_CONTROL, 8'h60);
    rd(IPRC_OFF_IRQ_CONTROL, 8'hc0);
    wr(IPRC_OFF_IRQ_CONTROL, 8'h80);
    rd(IPRC_OFF_IRQ_CONTROL, 8'h80);
    i_ext_int_n <= 1'b0;
    wirq(1'b0, 8'h00);
    i_ext_int_n <= 1'b1;
    wr(IPRC_OFF_IRQ_CONTROL, 8'hc0);
    i_ext_int_n <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    i_ext_int_n <= 1'b1;
    wirq(1'b1, 8'hf2);
    i_int_ack <= 1'b1;
    @(posedge i_clk_sys);
    i_int_ack <= 1'b0;
    wirq(1'b0, 8'h00);
    $display("control and edge done");
    wr(IPRC_OFF_PRIO_ELEV, 8'hf0);
    rd(IPRC_OFF_PRIO_ELEV, 8'hf2);
    i_cpu_i_mask <= 1'b1;
    wr(IPRC_OFF_PRIO_ELEV, 8'he0);
    i_cpu_i_mask <= 1'b0;
    rd(IPRC_OFF_PRIO_ELEV, 8'he0);
    src[2] <= 1'b1;
    src[9] <= 1'b1;
    wirq(1'b1, 8'he0);
    i_cpu_i_mask <= 1'b1;
    wr(IPRC_OFF_PRIO_ELEV, 8'he1);
    i_cpu_i_mask <= 1'b0;
    wirq(1'b1, 8'hee);
    src <= '0;
    wr(IPRC_OFF_TEST_LO, 8'hff);
    wirq(1'b0, 8'h00);
    rd(IPRC_OFF_TEST_LO, 8'h00);
    $display("priority and test regs done");
    wr(IPRC_OFF_WDOG_SERVICE, 8'h55);
    wr(IPRC_OFF_WDOG_SERVICE, 8'haa);
    repeat (5) @(posedge i_clk_sys);
    chk({7'h00, o_core_reset}, 8'h00);
    wr(IPRC_OFF_WDOG_SERVICE, 8'h12);
    rwait(lo);
    chk({4'h0, o_reset_vector}, {4'h0, IPRC_VEC_WDOG});
    chk({7'h00, lo >= 16}, 8'h01);
    wr(IPRC_OFF_WDOG_CTRL, 8'h81);
    wr(IPRC_OFF_WDOG_SERVICE, 8'h55);
    rwait(lo);
    chk({4'h0, o_reset_vector}, {4'h0, IPRC_VEC_WDOG});
    hold <= 1'b1;
    wr(IPRC_OFF_WDOG_SERVICE, 8'h12);
    hold <= 1'b0;
    rwait(lo);
    chk({4'h0, o_reset_vector}, {4'h0, IPRC_VEC_PIN});
    $display("watchdog and pin reset done");
    wr(IPRC_OFF_WDOG_CTRL, 8'h47);
    i_clk_slow <= 1'b1;
    rwait(lo);
    i_clk_slow <= 1'b0;
    chk({4'h0, o_reset_vector}, {4'h0, IPRC_VEC_CLKMON});
    chk({7'h00, lo >= OSC + 16}, 8'h01);
    rd(IPRC_OFF_WDOG_CTRL, 8'h07);
    wr(IPRC_OFF_PERIODIC, 8'h01);
    pev <= 1'b1;
    @(posedge i_clk_sys);
    pev <= 1'b0;
    rd(IPRC_OFF_PERIODIC, 8'h81);
    wr(IPRC_OFF_PERIODIC, 8'h81);
    rd(IPRC_OFF_PERIODIC, 8'h01);
    $display("clock monitor and periodic done");
    background_debug_pin <= 1'b0;
    i_reset <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    rwait(lo);
    chk({4'h0, o_reset_vector}, {4'h0, IPRC_VEC_PIN});
    chk({5'h00, o_mode}, 8'h01);
    rd(IPRC_OFF_PERIODIC, 8'h00);
    wr(IPRC_OFF_IRQ_CONTROL, 8'he0);
    rd(IPRC_OFF_IRQ_CONTROL, 8'h60);
    wr(IPRC_OFF_IRQ_CONTROL, 8'hc0);
    rd(IPRC_OFF_IRQ_CONTROL, 8'hc0);
    wr(IPRC_OFF_TEST_LO, 8'h01);
    src[21] <= 1'b1;
    wirq(1'b1, 8'hc8);
    rd(IPRC_OFF_TEST_LO, 8'h03);
    $display("special mode done");
    results();
  end
endmodule : iprc_top_test
bind iprc_top iprc_top_checker chk_i (.i_clk_sys(i_clk_sys),
  .i_reset(i_reset), .i_bus(i_bus), .o_rdata(o_rdata),
  .i_reset_pin(i_reset_pin), .o_reset_pin_oe_n(o_reset_pin_oe_n),
  .o_core_reset(o_core_reset), .o_reset_vector(o_reset_vector),
  .o_irq(o_irq), .o_cpu_mask_set(o_cpu_mask_set), .o_mode(o_mode));
`default_nettype wire
